/* File: design/wdtrg_pkg.sv */
// constants for the watchdog timer and reset guard
// assumes a 20 MHz mclk and a low-speed rc clock arriving on a pin
// Notes on behaviour
// - counter advances only on low-speed rc edges
// - selector picks divide 2^8 to 2^18
// - key 01010 enables, 10101 disables
// - other key: delayed full reset, flag set
// - power-on control value 0x53, enabled
// - key flag set by hardware, cleared by software
// - overflow while running: reset, timeout flag
// - overflow while halted: pc/sp reset only
// - counter cleared by key reset, clear, halt, pin
// - cause flag bits 7 to 4 read zero
// - cause flags at bits 3..0, zero at power-on
// - halt clears counter, resumes only if enabled
// - halt sets power-down, clears timeout flag
// - reset pin active only with select 10101010
package wdtrg_pkg;
    localparam logic [3:0]  ADDR_CONTROL     = 4'h0;
    localparam logic [3:0]  ADDR_CAUSE       = 4'h1;
    localparam logic [3:0]  ADDR_PIN_SELECT  = 4'h2;
    localparam logic [3:0]  ADDR_STATUS      = 4'h3;
    localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_MASK    = 4'h5;
    localparam logic [7:0]  CONTROL_RESET    = 8'h53;
    localparam logic [7:0]  PIN_SELECT_RESET = 8'h55;
    localparam logic [7:0]  PIN_SELECT_KEY   = 8'haa;
    localparam logic [7:0]  PIN_IO_KEY       = 8'h55;
    localparam logic [4:0]  KEY_ENABLE       = 5'h0a;
    localparam logic [4:0]  KEY_DISABLE      = 5'h15;
    localparam int          KEY_MSB          = 7;
    localparam int          KEY_LSB          = 3;
    localparam int          SEL_MSB          = 2;
    localparam int          BIT_PIN_KEY_FLAG = 3;
    localparam int          BIT_LV_EVENT     = 2;
    localparam int          BIT_LV_KEY       = 1;
    localparam int          BIT_WDT_KEY_FLAG = 0;
    localparam int          BIT_TIMEOUT      = 0;
    localparam int          BIT_POWER_DOWN   = 1;
    localparam int          COUNT_W          = 18;
    // software-reset delay in ns, rounded up to mclk cycles
    localparam int          SRESET_NS        = 1000;
    localparam int          CLK_NS           = 50;
    localparam logic [7:0]  SRESET_CYCLES    = 8'((SRESET_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  SYS_RESET_CYCLES = 8'h10;
    localparam int          IRQ_W            = 3;
endpackage : wdtrg_pkg

/* File: design/wdtrg_top.sv */
// watchdog timer with keyed control, reset cause flags and reset pin guard
// assumes avalon-mm master on mclk; rc clock and reset pin are asynchronous pins
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
module wdtrg_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // cpu side
    input  wire logic        clear_pulse,
    input  wire logic        halt_pulse,
    input  wire logic        low_voltage_event,
    // pins
    input  wire logic        low_speed_rc_oscillator_pin,
    input  wire logic        reset_pin_b,
    // reset and interrupt outputs
    output logic             device_reset,
    output logic             warm_reset,
    output logic             irq
);
    logic [2:0]         low_speed_rc_oscillator_sync;
    logic [1:0]         rpin_sync;
    logic               low_speed_rc_oscillator_tick;
    logic [7:0]         watchdog_control;
    logic [7:0]         pin_select;
    logic [3:0]         cause;
    logic               timeout_flag;
    logic               power_down;
    logic               asleep;
    logic [2:0]         irq_status;
    logic [2:0]         irq_mask;
    logic [wdtrg_pkg::COUNT_W-1:0] count;
    logic               overflow;
    logic               bad_key;
    logic               bad_pin;
    logic               pin_reset;
    logic [7:0]         sreset_cnt;
    logic               sreset_busy;
    logic               sreset_wdt;
    logic [7:0]         reset_cnt;
    logic               wr_hit;
    logic               rd_hit;
    logic [31:0]        next_readdata;

    function automatic logic [wdtrg_pkg::COUNT_W-1:0] limit_of(input logic [2:0] sel);
        logic [4:0]  exp;
        logic [18:0] full;
        exp      = (sel < 3'h4) ? 5'(8 + 2 * sel) : 5'(11 + sel);
        full     = (19'h1 << exp) - 19'h1;
        limit_of = full[wdtrg_pkg::COUNT_W-1:0];
    endfunction : limit_of

    function automatic logic key_on(input logic [7:0] ctrl);
        key_on = ctrl[wdtrg_pkg::KEY_MSB:wdtrg_pkg::KEY_LSB] == wdtrg_pkg::KEY_ENABLE;
    endfunction : key_on

    // two-stage sync, then edge detect on the second and third stages
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            low_speed_rc_oscillator_sync <= 3'h0;
            rpin_sync <= 2'h3;
        end else begin
            low_speed_rc_oscillator_sync <= {low_speed_rc_oscillator_sync[1:0], low_speed_rc_oscillator_pin};
            rpin_sync <= {rpin_sync[0], reset_pin_b};
        end
    end
    assign low_speed_rc_oscillator_tick = low_speed_rc_oscillator_sync[1] & ~low_speed_rc_oscillator_sync[2];

    assign wr_hit    = avs_write & ~avs_waitrequest;
    assign rd_hit    = avs_read & ~avs_waitrequest;
    assign bad_key   = watchdog_control[wdtrg_pkg::KEY_MSB:wdtrg_pkg::KEY_LSB] != wdtrg_pkg::KEY_ENABLE
                    && watchdog_control[wdtrg_pkg::KEY_MSB:wdtrg_pkg::KEY_LSB] != wdtrg_pkg::KEY_DISABLE;
    assign bad_pin   = pin_select != wdtrg_pkg::PIN_SELECT_KEY && pin_select != wdtrg_pkg::PIN_IO_KEY;
    assign pin_reset = (pin_select == wdtrg_pkg::PIN_SELECT_KEY) & ~rpin_sync[1];
    // at or past the limit, so a shortened period still ends
    assign overflow  = low_speed_rc_oscillator_tick && key_on(watchdog_control)
                    && count >= limit_of(watchdog_control[wdtrg_pkg::SEL_MSB:0]);

    // one-cycle waitrequest per access: answer on the second cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // control registers survive a warm reset, restored on a full one
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_control <= wdtrg_pkg::CONTROL_RESET;
            pin_select       <= wdtrg_pkg::PIN_SELECT_RESET;
        end else if (device_reset) begin
            watchdog_control <= wdtrg_pkg::CONTROL_RESET;
            pin_select       <= wdtrg_pkg::PIN_SELECT_RESET;
        end else if (wr_hit && avs_address == wdtrg_pkg::ADDR_CONTROL) begin
            watchdog_control <= avs_writedata[7:0];
        end else if (wr_hit && avs_address == wdtrg_pkg::ADDR_PIN_SELECT) begin
            pin_select       <= avs_writedata[7:0];
        end
    end

    // watchdog counter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (device_reset || warm_reset || sreset_wdt || clear_pulse || halt_pulse || pin_reset) begin
            count <= '0;
        end else if (overflow) begin
            count <= '0;
        end else if (low_speed_rc_oscillator_tick && key_on(watchdog_control)) begin
            count <= count + 1'b1;
        end
    end

    // software-reset delay for a corrupted key register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sreset_cnt  <= 8'h0;
            sreset_busy <= 1'b0;
            sreset_wdt  <= 1'b0;
        end else if (device_reset) begin
            sreset_cnt  <= 8'h0;
            sreset_busy <= 1'b0;
            sreset_wdt  <= 1'b0;
        end else if (!sreset_busy && (bad_key || bad_pin)) begin
            sreset_busy <= 1'b1;
            sreset_wdt  <= bad_key;
            sreset_cnt  <= wdtrg_pkg::SRESET_CYCLES;
        end else if (sreset_busy && sreset_cnt != 8'h0) begin
            sreset_cnt  <= sreset_cnt - 8'h1;
        end
    end

    // full and warm reset pulses
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reset_cnt    <= 8'h0;
            device_reset <= 1'b0;
            warm_reset   <= 1'b0;
        end else begin
            warm_reset <= overflow & asleep;
            if ((sreset_busy && sreset_cnt == 8'h1) || (overflow && !asleep) || pin_reset) begin
                reset_cnt    <= wdtrg_pkg::SYS_RESET_CYCLES;
                device_reset <= 1'b1;
            end else if (reset_cnt != 8'h0) begin
                reset_cnt    <= reset_cnt - 8'h1;
                device_reset <= reset_cnt != 8'h1;
            end else begin
                device_reset <= 1'b0;
            end
        end
    end

    // reset cause flags, hardware set wins over software clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cause <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_hit && avs_address == wdtrg_pkg::ADDR_CAUSE && !avs_writedata[i]) begin
                    cause[i] <= 1'b0;
                end
            end
            if (sreset_busy && sreset_cnt == 8'h1) begin
                if (sreset_wdt) begin
                    cause[wdtrg_pkg::BIT_WDT_KEY_FLAG] <= 1'b1;
                end else begin
                    cause[wdtrg_pkg::BIT_PIN_KEY_FLAG] <= 1'b1;
                end
            end
            if (low_voltage_event) begin
                cause[wdtrg_pkg::BIT_LV_EVENT] <= 1'b1;
            end
        end
    end

    // status flags and sleep state
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            timeout_flag <= 1'b0;
            power_down   <= 1'b0;
            asleep       <= 1'b0;
        end else if (overflow) begin
            timeout_flag <= 1'b1;
            asleep       <= 1'b0;
        end else if (halt_pulse) begin
            power_down   <= 1'b1;
            timeout_flag <= 1'b0;
            asleep       <= 1'b1;
        end else if (clear_pulse) begin
            power_down   <= 1'b0;
            timeout_flag <= 1'b0;
        end else if (device_reset && !timeout_flag) begin
            power_down   <= 1'b0;
            asleep       <= 1'b0;
        end
    end

    // interrupts: timeout, key fault, halt wake by overflow
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= 3'h0;
            irq_mask   <= 3'h0;
            irq        <= 1'b0;
        end else begin
            for (int i = 0; i < wdtrg_pkg::IRQ_W; i++) begin
                if ((i == 0 && overflow) || (i == 1 && !sreset_busy && bad_key) || (i == 2 && warm_reset)) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_hit && avs_address == wdtrg_pkg::ADDR_IRQ_STATUS && avs_writedata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
            if (wr_hit && avs_address == wdtrg_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= avs_writedata[2:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    always_comb begin
        next_readdata = 32'h0;
        unique case (avs_address)
            wdtrg_pkg::ADDR_CONTROL:    next_readdata[7:0] = watchdog_control;
            wdtrg_pkg::ADDR_CAUSE:      next_readdata[3:0] = cause;
            wdtrg_pkg::ADDR_PIN_SELECT: next_readdata[7:0] = pin_select;
            wdtrg_pkg::ADDR_STATUS:     next_readdata[1:0] = {power_down, timeout_flag};
            wdtrg_pkg::ADDR_IRQ_STATUS: next_readdata[2:0] = irq_status;
            wdtrg_pkg::ADDR_IRQ_MASK:   next_readdata[2:0] = irq_mask;
            default:                    next_readdata = 32'h0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    upper_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_hit && avs_address == wdtrg_pkg::ADDR_CAUSE |-> avs_readdata[31:4] == 28'h0)
        else $error("cause upper bits not zero");
    tick_only_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !low_speed_rc_oscillator_tick && !device_reset |=> count == $past(count) || count == '0)
        else $error("counter moved without rc tick");
    halt_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        halt_pulse && !overflow |=> count == '0 && power_down && !timeout_flag)
        else $error("halt effects missing");
    clear_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clear_pulse |=> count == '0)
        else $error("clear did not zero counter");
    bad_key_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sreset_busy && sreset_cnt == 8'h1 && sreset_wdt |=> device_reset && cause[0])
        else $error("bad key reset missing");
    overflow_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
        overflow && !asleep |=> device_reset && timeout_flag)
        else $error("overflow reset missing");
    overflow_sleep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        overflow && asleep |=> warm_reset && timeout_flag && !device_reset)
        else $error("sleep overflow wrong");
    pin_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !rpin_sync[1] && pin_select != wdtrg_pkg::PIN_SELECT_KEY && !$past(pin_reset) && reset_cnt == 8'h0
        && !(sreset_busy && sreset_cnt == 8'h1) && !overflow |=> !device_reset)
        else $error("pin reset while not selected");
    disabled_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        watchdog_control[7:3] == wdtrg_pkg::KEY_DISABLE |-> !overflow)
        else $error("overflow while disabled");
    wait_one_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait cycle");
    wait_back_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    rd_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_hit && avs_address > wdtrg_pkg::ADDR_IRQ_MASK |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    write_ctrl_a: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_hit && avs_address == wdtrg_pkg::ADDR_CONTROL && !device_reset
        |=> watchdog_control == $past(avs_writedata[7:0]))
        else $error("control write lost");
    full_restore_a: assert property (@(posedge mclk) disable iff (!rst_b)
        device_reset |=> watchdog_control == wdtrg_pkg::CONTROL_RESET && pin_select == wdtrg_pkg::PIN_SELECT_RESET)
        else $error("full reset left control changed");
    warm_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        warm_reset && !device_reset && !wr_hit |=> watchdog_control == $past(watchdog_control))
        else $error("warm reset touched control");
    flag_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !(wr_hit && avs_address == wdtrg_pkg::ADDR_CAUSE) |=> (cause & $past(cause)) == $past(cause))
        else $error("cause flag cleared by hardware");
    cause_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_hit && avs_address == wdtrg_pkg::ADDR_CAUSE && !avs_writedata[0]
        && !(sreset_busy && sreset_cnt == 8'h1) |=> !cause[0])
        else $error("cause flag not cleared");
    key_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !sreset_busy && bad_key && !device_reset |=> sreset_busy && sreset_wdt
        && sreset_cnt == wdtrg_pkg::SRESET_CYCLES)
        else $error("key fault delay not started");
    no_early_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sreset_busy && sreset_cnt > 8'h1 && reset_cnt == 8'h0 && !pin_reset && !overflow
        |=> !device_reset)
        else $error("reset before delay ran out");
    pin_key_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sreset_busy && sreset_cnt == 8'h1 && !sreset_wdt |=> device_reset && cause[wdtrg_pkg::BIT_PIN_KEY_FLAG])
        else $error("pin select fault not flagged");
    count_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
        low_speed_rc_oscillator_tick && key_on(watchdog_control) && !overflow && !device_reset && !warm_reset && !sreset_wdt
        && !clear_pulse && !halt_pulse && !pin_reset |=> count == $past(count) + 1'b1)
        else $error("counter missed an rc tick");
    disabled_stop_a: assert property (@(posedge mclk) disable iff (!rst_b)
        watchdog_control[7:3] == wdtrg_pkg::KEY_DISABLE |=> count == $past(count) || count == '0)
        else $error("counter ran while disabled");
    sync_tick_a: assert property (@(posedge mclk) disable iff (!rst_b)
        low_speed_rc_oscillator_tick |=> !low_speed_rc_oscillator_tick)
        else $error("rc tick longer than one cycle");
    pin_fire_a: assert property (@(posedge mclk) disable iff (!rst_b)
        pin_reset |=> device_reset)
        else $error("selected pin did not reset");
    pin_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        pin_reset |=> count == '0)
        else $error("pin did not clear counter");
    sleep_enter_a: assert property (@(posedge mclk) disable iff (!rst_b)
        halt_pulse && !overflow |=> asleep)
        else $error("halt did not enter sleep");
    wake_a: assert property (@(posedge mclk) disable iff (!rst_b)
        overflow |=> !asleep && warm_reset == $past(asleep))
        else $error("overflow wake wrong");
    warm_one_a: assert property (@(posedge mclk) disable iff (!rst_b)
        warm_reset |=> !warm_reset)
        else $error("warm reset longer than one cycle");
    clear_flags_a: assert property (@(posedge mclk) disable iff (!rst_b)
        clear_pulse && !overflow && !halt_pulse |=> !power_down && !timeout_flag)
        else $error("clear left status flags");
    reset_len_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(device_reset) |-> device_reset [*8])
        else $error("full reset pulse too short");
    lv_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
        low_voltage_event |=> cause[wdtrg_pkg::BIT_LV_EVENT])
        else $error("low voltage flag not set");
    irq_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
        overflow |=> irq_status[0])
        else $error("overflow event not latched");
    irq_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
        irq |-> ($past(irq_status) & $past(irq_mask)) != 3'h0)
        else $error("irq without unmasked event");
endmodule : wdtrg_top

/* File: verification/tb_top.sv */
// self-checking bench for the watchdog timer and reset guard
// assumes wdtrg_pkg and wdtrg_top compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk              = 1'b0;
    logic        rst_b;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic        low_voltage_event;
    logic        reset_pin_b;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, clear_pulse, halt_pulse, low_speed_rc_oscillator_pin, device_reset, warm_reset, irq;
    logic [15:0] n_dr = 16'h0, n_wr = 16'h0, b_dr, b_wr;
    logic [7:0]  q;
    int          n_mismatch = 0, cmp_count = 0, cyc = 0;

    wdtrg_top wdtrg_top_inst (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .clear_pulse(clear_pulse), .halt_pulse(halt_pulse),
        .low_voltage_event(low_voltage_event), .low_speed_rc_oscillator_pin(low_speed_rc_oscillator_pin), .reset_pin_b(reset_pin_b),
        .device_reset(device_reset), .warm_reset(warm_reset), .irq(irq));
    wdtrg_cpu_model cpu_inst (.mclk(mclk), .low_speed_rc_oscillator_pin(low_speed_rc_oscillator_pin), .clear_pulse(clear_pulse),
        .halt_pulse(halt_pulse));

    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        n_dr <= n_dr + {15'h0, device_reset};
        n_wr <= n_wr + {15'h0, warm_reset};
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task wrap_up;
        if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // avalon-mm access held until waitrequest is sampled low at a rising edge
    task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h0, d};
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task pins(input logic lv, input logic pin);
        low_voltage_event <= lv;
        reset_pin_b <= pin;
    endtask : pins
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 8'h00);
        chk(q, exp);
    endtask : rd
    task mark;
        b_dr = n_dr;
        b_wr = n_wr;
    endtask : mark
    // whether full or warm reset fired since mark
    task seen(input logic e_dr, input logic e_wr);
        chk({6'h0, n_wr != b_wr, n_dr != b_dr}, {6'h0, e_wr, e_dr});
    endtask : seen

    initial begin
        rst_b = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        pins(1'b0, 1'b1);
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        rd(wdtrg_pkg::ADDR_CONTROL, wdtrg_pkg::CONTROL_RESET);
        rd(wdtrg_pkg::ADDR_CAUSE, 8'h00);
        rd(wdtrg_pkg::ADDR_PIN_SELECT, wdtrg_pkg::PIN_SELECT_RESET);
        wr(4'h6, 8'hff);
        rd(4'h6, 8'h00);
        wr(wdtrg_pkg::ADDR_CONTROL, {wdtrg_pkg::KEY_ENABLE, 3'h0});
        mark();
        repeat (3) begin
            cpu_inst.pulse(1'b0);
            cpu_inst.ticks(200);
        end
        seen(1'b0, 1'b0);
        repeat (3000) @(posedge mclk);
        seen(1'b0, 1'b0);
        for (int s = 0; s < 2; s++) begin
            wr(wdtrg_pkg::ADDR_CONTROL, {wdtrg_pkg::KEY_ENABLE, 3'(s)});
            cpu_inst.pulse(1'b0);
            mark();
            cpu_inst.ticks((1 << (8 + 2 * s)) - 4);
            seen(1'b0, 1'b0);
            mark();
            cpu_inst.ticks(8);
            seen(1'b1, 1'b0);
            rd(wdtrg_pkg::ADDR_STATUS, 8'h01);
            rd(wdtrg_pkg::ADDR_CONTROL, wdtrg_pkg::CONTROL_RESET);
        end
        wr(wdtrg_pkg::ADDR_CONTROL, {wdtrg_pkg::KEY_ENABLE, 3'h0});
        cpu_inst.pulse(1'b1);
        rd(wdtrg_pkg::ADDR_STATUS, 8'h02);
        mark();
        cpu_inst.ticks(252);
        seen(1'b0, 1'b0);
        mark();
        cpu_inst.ticks(8);
        seen(1'b0, 1'b1);
        rd(wdtrg_pkg::ADDR_STATUS, 8'h03);
        rd(wdtrg_pkg::ADDR_CONTROL, {wdtrg_pkg::KEY_ENABLE, 3'h0});
        cpu_inst.pulse(1'b0);
        rd(wdtrg_pkg::ADDR_STATUS, 8'h00);
        wr(wdtrg_pkg::ADDR_CONTROL, {wdtrg_pkg::KEY_DISABLE, 3'h0});
        cpu_inst.pulse(1'b1);
        mark();
        cpu_inst.ticks(300);
        seen(1'b0, 1'b0);
        wr(wdtrg_pkg::ADDR_CONTROL, 8'h03);
        mark();
        repeat (10) @(posedge mclk);
        seen(1'b0, 1'b0);
        repeat (40) @(posedge mclk);
        seen(1'b1, 1'b0);
        rd(wdtrg_pkg::ADDR_CONTROL, wdtrg_pkg::CONTROL_RESET);
        @(posedge mclk) pins(1'b1, 1'b1);
        @(posedge mclk) pins(1'b0, 1'b1);
        rd(wdtrg_pkg::ADDR_CAUSE, 8'h05);
        mark();
        @(posedge mclk) pins(1'b0, 1'b0);
        repeat (10) @(posedge mclk);
        seen(1'b0, 1'b0);
        wr(wdtrg_pkg::ADDR_PIN_SELECT, wdtrg_pkg::PIN_SELECT_KEY);
        mark();
        repeat (10) @(posedge mclk);
        seen(1'b1, 1'b0);
        @(posedge mclk) pins(1'b0, 1'b1);
        repeat (20) @(posedge mclk);
        rd(wdtrg_pkg::ADDR_PIN_SELECT, wdtrg_pkg::PIN_SELECT_RESET);
        wr(wdtrg_pkg::ADDR_PIN_SELECT, 8'h12);
        mark();
        repeat (50) @(posedge mclk);
        seen(1'b1, 1'b0);
        rd(wdtrg_pkg::ADDR_CAUSE, 8'h0d);
        wr(wdtrg_pkg::ADDR_CAUSE, 8'hff);
        rd(wdtrg_pkg::ADDR_CAUSE, 8'h0d);
        wr(wdtrg_pkg::ADDR_CAUSE, 8'h00);
        rd(wdtrg_pkg::ADDR_CAUSE, 8'h00);
        rd(wdtrg_pkg::ADDR_IRQ_STATUS, 8'h07);
        wr(wdtrg_pkg::ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge mclk);
        chk({7'h0, irq}, 8'h00);
        wr(wdtrg_pkg::ADDR_IRQ_MASK, 8'h07);
        repeat (2) @(posedge mclk);
        chk({7'h0, irq}, 8'h01);
        wr(wdtrg_pkg::ADDR_IRQ_STATUS, 8'h07);
        rd(wdtrg_pkg::ADDR_IRQ_STATUS, 8'h00);
        repeat (2) @(posedge mclk);
        chk({7'h0, irq}, 8'h00);
        wrap_up();
    end
endmodule : tb_top

/* File: verification/wdtrg_cpu_model.sv */
// cpu core and rc oscillator model driving the watchdog's far side
// assumes mclk from the bench; rc clock stands low between bursts
module wdtrg_cpu_model (
    // clock
    input  wire logic mclk,
    // to the watchdog
    output logic      low_speed_rc_oscillator_pin,
    output logic      clear_pulse,
    output logic      halt_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        low_speed_rc_oscillator_pin = 1'b0;
        clear_pulse = 1'b0;
        halt_pulse = 1'b0;
    end
    // rc ticks sped up to 8 mclk periods each
    task automatic ticks(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge mclk);
            low_speed_rc_oscillator_pin <= !low_speed_rc_oscillator_pin;
            repeat (4) @(posedge mclk);
            low_speed_rc_oscillator_pin <= 1'b0;
        end
    endtask : ticks
    // one-cycle clear or halt instruction
    task automatic pulse(input logic halt);
        @(posedge mclk);
        halt_pulse <= halt;
        clear_pulse <= !halt;
        @(posedge mclk);
        halt_pulse <= 1'b0;
        clear_pulse <= 1'b0;
    endtask : pulse
endmodule : wdtrg_cpu_model
